// ### core/mse_pkg.sv
// constants and types shared by the motion sequence executor
package mse_pkg;
  // sequence kind codes held in the type sub-entry
  localparam logic [7:0]  KIND_POS     = 8'h01;
  localparam logic [7:0]  KIND_HOME    = 8'h02;
  localparam logic [7:0]  KIND_SPEED   = 8'h03;
  localparam logic [7:0]  KIND_TORQUE  = 8'h04;
  // run duration value meaning endless
  localparam logic [15:0] RUN_ENDLESS  = 16'hFFFF;
  // control word bit positions
  localparam int          CW_START_BIT = 4;
  localparam int          CW_STOP_BIT  = 5;
  // sequence memory depth and entry index width
  localparam int          SEQ_DEPTH    = 128;
  localparam int          IDX_W        = 7;
  // one millisecond of clock cycles at 10 MHz
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          MS_PER_S     = 1000;
  localparam int          MS_CYCLES    = CLK_HZ / MS_PER_S;
  localparam logic [13:0] MS_LAST      = 14'(MS_CYCLES - 1);
  // mechanical-limit homing method range
  localparam logic signed [7:0] HOME_MECH_LO = -8'sd4;
  localparam logic signed [7:0] HOME_MECH_HI = -8'sd1;
  // current cap when no cap applies, per thousand of rated
  localparam logic [15:0] CAP_NONE     = 16'hFFFF;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  ZERO8        = 8'h00;

  // sequencer phases
  typedef enum logic [2:0] {
    MSE_IDLE  = 3'b000,
    MSE_LOAD  = 3'b001,
    MSE_RAMP  = 3'b010,
    MSE_RUN   = 3'b011,
    MSE_HOLD  = 3'b100,
    MSE_DECEL = 3'b101,
    MSE_DONE  = 3'b110
  } mse_phase_e;
endpackage : mse_pkg

// ### core/mse_top.sv
// motion sequence executor core
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - kind code 1 selects a positioning sequence
// - kind code 2 selects a homing sequence
// - kind code 3 selects a speed-profile sequence
// - positioning uses velocity, final velocity and target position fields
// - positioning uses acceleration and deceleration fields
// - homing uses method field; home point loads position with offset
// - homing searches switch at velocity, zero mark at final velocity
// - homing methods -1 to -4 cap motor current at current_cap
// - homing behaves like the standalone homing mode with own parameters
// - speed sequence uses ramp-up and ramp-down durations in ms
// - run phase timed in ms; 65535 means endless
// - endless speed sequence ends only on the stop condition
// - speed sequence with zero ramp-down ends right after running phase
// - speed sequence velocity reduced by speed modulation when configured
// - torque sequence runs at velocity until current reaches current_cap
// - torque direction follows velocity sign
// - at cap, hold current for run_duration; 65535 endless until stop
// - torque hold expiry latches motor position into capture position
// - following-error detection suppressed while torque sequence runs
// - torque sequence velocity reduced by speed modulation
// - torque sequences refused when running without position sensor
// - kind code 4 selects a torque sequence
// - rising edge of control bit 4 starts, bit 5 stops
// - after completion go to following entry while counter nonzero
// - unmet launch condition skips sequence to alternate entry
module mse_top (
  input  wire logic                 clk_sys,        // drive clock, 10 MHz
  input  wire logic                 arst_n,         // async reset, low
  input  wire logic [15:0]          ctrl_word,      // control word
  input  wire logic [6:0]           seq_select,     // selected entry
  input  wire logic [15:0]          cond_inputs,    // logic inputs
  input  wire logic                 sensorless,     // no position sensor
  input  wire logic                 mod_enable,     // modulation configured
  input  wire logic [31:0]          mod_value,      // speed modulation
  input  wire logic [31:0]          motor_pos,      // present position
  input  wire logic [15:0]          motor_current,  // current, per mille
  input  wire logic                 target_reached, // loop reached target
  input  wire logic                 home_point,     // homing point found
  input  wire logic                 switch_found,   // homing switch seen
  input  wire logic                 prm_we,         // parameter write
  input  wire logic [6:0]           prm_entry,      // entry to write
  input  wire logic [4:0]           prm_sub,        // sub-entry number
  input  wire logic [31:0]          prm_wdata,      // write data
  input  wire logic                 prm_re,         // capture read strobe
  output logic      [31:0]          prm_rdata,      // capture read data
  output logic      [2:0]           mode_o,         // 1 pos 2 home 3 spd 4 trq
  output logic signed [31:0]        vel_sp_o,       // velocity setpoint
  output logic      [31:0]          pos_sp_o,       // position setpoint
  output logic      [31:0]          accel_o,        // acceleration
  output logic      [31:0]          decel_o,        // deceleration
  output logic      [15:0]          cur_cap_o,      // current cap
  output logic signed [7:0]         home_method_o,  // homing method
  output logic                      pos_load_o,     // load position pulse
  output logic      [31:0]          pos_load_val_o, // value to load
  output logic                      ferr_off_o,     // following error off
  output logic      [31:0]          capture_pos_o,  // capture position
  output logic                      busy_o,         // sequence active
  output logic      [6:0]           exec_entry_o    // executing entry
);

  // ==========================================================
  // sequence memory
  localparam int DEPTH = mse_pkg::SEQ_DEPTH; // entries held
  logic [7:0]  kind_m [DEPTH], count_m [DEPTH], meth_m [DEPTH];
  logic [6:0]  next_m [DEPTH], alt_m [DEPTH];
  logic [15:0] lc0_m [DEPTH], lc1_m [DEPTH], sc0_m [DEPTH], sc1_m [DEPTH];
  logic [15:0] upd_m [DEPTH], dnd_m [DEPTH], run_m [DEPTH], cap_m [DEPTH];
  logic [31:0] pos_m [DEPTH], vel_m [DEPTH], fvel_m [DEPTH];
  logic [31:0] acc_m [DEPTH], dec_m [DEPTH];

  // parameter writes by sub-entry number
  always_ff @(posedge clk_sys) begin
    if (prm_we) begin
      unique case (prm_sub)
        5'd1:  kind_m[prm_entry]  <= prm_wdata[7:0];
        5'd2:  next_m[prm_entry]  <= prm_wdata[6:0];
        5'd3:  count_m[prm_entry] <= prm_wdata[7:0];
        5'd4:  alt_m[prm_entry]   <= prm_wdata[6:0];
        5'd9:  lc0_m[prm_entry]   <= prm_wdata[15:0];
        5'd10: lc1_m[prm_entry]   <= prm_wdata[15:0];
        5'd11: sc0_m[prm_entry]   <= prm_wdata[15:0];
        5'd12: sc1_m[prm_entry]   <= prm_wdata[15:0];
        5'd13: pos_m[prm_entry]   <= prm_wdata;
        5'd15: vel_m[prm_entry]   <= prm_wdata;
        5'd16: fvel_m[prm_entry]  <= prm_wdata;
        5'd17: acc_m[prm_entry]   <= prm_wdata;
        5'd18: dec_m[prm_entry]   <= prm_wdata;
        5'd19: upd_m[prm_entry]   <= prm_wdata[15:0];
        5'd20: dnd_m[prm_entry]   <= prm_wdata[15:0];
        5'd22: meth_m[prm_entry]  <= prm_wdata[7:0];
        5'd24: run_m[prm_entry]   <= prm_wdata[15:0];
        5'd25: cap_m[prm_entry]   <= prm_wdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // control word start edge and stop level
  logic start_d_r;
  logic start_rise, stop_req;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) start_d_r <= 1'b0;
    else         start_d_r <= ctrl_word[mse_pkg::CW_START_BIT];
  end
  assign start_rise = ctrl_word[mse_pkg::CW_START_BIT] & ~start_d_r;
  assign stop_req   = ctrl_word[mse_pkg::CW_STOP_BIT];

  // ==========================================================
  // sequencer state
  mse_pkg::mse_phase_e phase_r;
  logic [6:0]  cur_r, chain_to;
  logic [7:0]  kind_r, left_r, ck;
  logic [13:0] tick_r;
  logic [15:0] ms_r, run_len;
  logic        counting_r, ms_tick, endless, launch_ok;
  logic        stop_cond, kind_ok, cap_hit;
  assign ck        = kind_m[cur_r];
  assign run_len   = run_m[cur_r];
  assign endless   = (run_len == mse_pkg::RUN_ENDLESS);
  // launch condition: bits required low and high; none defined passes
  assign launch_ok = ((cond_inputs & lc0_m[cur_r]) == mse_pkg::ZERO16) &&
                     ((cond_inputs & lc1_m[cur_r]) == lc1_m[cur_r]);
  assign stop_cond = ((sc0_m[cur_r] | sc1_m[cur_r]) != mse_pkg::ZERO16) &&
                     ((cond_inputs & sc0_m[cur_r]) == mse_pkg::ZERO16) &&
                     ((cond_inputs & sc1_m[cur_r]) == sc1_m[cur_r]);
  // supported kinds, torque refused without a position sensor
  assign kind_ok   = (ck == mse_pkg::KIND_POS) ||
                     (ck == mse_pkg::KIND_HOME) ||
                     (ck == mse_pkg::KIND_SPEED) ||
                     ((ck == mse_pkg::KIND_TORQUE) && !sensorless);
  assign cap_hit   = (motor_current >= cap_m[cur_r]);
  // following entry while counter runs, alternate on its expiring pass
  assign chain_to  = (counting_r && left_r == 8'h01) ?
                     alt_m[cur_r] : next_m[cur_r];
  // millisecond tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)                    tick_r <= '0;
    else if (tick_r == mse_pkg::MS_LAST) tick_r <= '0;
    else                            tick_r <= tick_r + 14'h0001;
  end
  assign ms_tick = (tick_r == mse_pkg::MS_LAST);
  // phase machine
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_r    <= mse_pkg::MSE_IDLE;
      cur_r      <= '0;
      kind_r     <= '0;
      left_r     <= '0;
      counting_r <= 1'b0;
      ms_r       <= '0;
    end else if (stop_req && phase_r != mse_pkg::MSE_IDLE) begin
      phase_r <= mse_pkg::MSE_IDLE;
    end else begin
      unique case (phase_r)
        mse_pkg::MSE_IDLE: if (start_rise) begin
          cur_r      <= seq_select;
          counting_r <= 1'b0;
          phase_r    <= mse_pkg::MSE_LOAD;
        end
        mse_pkg::MSE_LOAD: begin
          ms_r <= '0;
          if (!launch_ok) begin
            cur_r <= alt_m[cur_r];
          end else if (!kind_ok) begin
            phase_r <= mse_pkg::MSE_IDLE;
          end else begin
            kind_r <= ck;
            if (!counting_r && count_m[cur_r] != mse_pkg::ZERO8) begin
              counting_r <= 1'b1;
              left_r     <= count_m[cur_r];
            end
            phase_r <= mse_pkg::MSE_RAMP;
          end
        end
        mse_pkg::MSE_RAMP: begin
          if (ms_tick) ms_r <= ms_r + 16'h0001;
          unique case (kind_r)
            mse_pkg::KIND_SPEED:
              if (ms_r >= upd_m[cur_r]) begin
                ms_r    <= '0;
                phase_r <= mse_pkg::MSE_RUN;
              end
            mse_pkg::KIND_TORQUE:
              if (cap_hit) begin
                ms_r    <= '0;
                phase_r <= mse_pkg::MSE_HOLD;
              end
            mse_pkg::KIND_HOME:
              if (home_point) phase_r <= mse_pkg::MSE_DONE;
            default:
              if (target_reached) phase_r <= mse_pkg::MSE_DONE;
          endcase
        end
        mse_pkg::MSE_RUN: begin
          if (ms_tick && !endless) ms_r <= ms_r + 16'h0001;
          if ((endless && stop_cond) ||
              (!endless && (ms_r >= run_len || stop_cond))) begin
            ms_r    <= '0;
            phase_r <= (dnd_m[cur_r] == mse_pkg::ZERO16) ?
                       mse_pkg::MSE_DONE : mse_pkg::MSE_DECEL;
          end
        end
        mse_pkg::MSE_HOLD: begin
          if (ms_tick && !endless) ms_r <= ms_r + 16'h0001;
          if ((endless && stop_cond) ||
              (!endless && ms_r >= run_len))
            phase_r <= mse_pkg::MSE_DONE;
        end
        mse_pkg::MSE_DECEL: begin
          if (ms_tick) ms_r <= ms_r + 16'h0001;
          if (ms_r >= dnd_m[cur_r]) phase_r <= mse_pkg::MSE_DONE;
        end
        mse_pkg::MSE_DONE: begin
          if (counting_r) left_r <= left_r - 8'h01;
          if (counting_r && left_r == 8'h01) counting_r <= 1'b0;
          cur_r   <= chain_to;
          phase_r <= mse_pkg::MSE_LOAD;
        end
        default: phase_r <= mse_pkg::MSE_IDLE;
      endcase
    end
  end

  // ==========================================================
  // setpoint outputs
  logic [31:0] vel_mag, vel_red;
  logic        vel_neg, mech_home;
  assign vel_neg   = vel_m[cur_r][31];
  assign vel_mag   = vel_neg ? (~vel_m[cur_r] + 32'h1) : vel_m[cur_r];
  // modulation reduces magnitude, clamped at zero
  assign vel_red   = (!mod_enable) ? vel_mag :
                     (mod_value >= vel_mag) ? '0 :
                     (vel_mag - mod_value);
  assign mech_home = ($signed(meth_m[cur_r]) >= mse_pkg::HOME_MECH_LO) &&
                     ($signed(meth_m[cur_r]) <= mse_pkg::HOME_MECH_HI);
  // registered setpoints per kind
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_o        <= '0;
      vel_sp_o      <= '0;
      pos_sp_o      <= '0;
      accel_o       <= '0;
      decel_o       <= '0;
      cur_cap_o     <= mse_pkg::CAP_NONE;
      home_method_o <= '0;
    end else if (phase_r == mse_pkg::MSE_IDLE) begin
      vel_sp_o  <= '0;
      mode_o    <= '0;
      cur_cap_o <= mse_pkg::CAP_NONE;
    end else if (phase_r != mse_pkg::MSE_LOAD) begin
      mode_o <= kind_r[2:0];
      unique case (kind_r)
        mse_pkg::KIND_POS: begin
          vel_sp_o <= vel_m[cur_r];
          pos_sp_o <= pos_m[cur_r];
          accel_o  <= acc_m[cur_r];
          decel_o  <= dec_m[cur_r];
          if (target_reached)
            vel_sp_o <= fvel_m[cur_r];
        end
        mse_pkg::KIND_HOME: begin
          home_method_o <= meth_m[cur_r];
          vel_sp_o  <= switch_found ? fvel_m[cur_r] : vel_m[cur_r];
          accel_o   <= 32'(upd_m[cur_r]);
          cur_cap_o <= mech_home ? cap_m[cur_r] : mse_pkg::CAP_NONE;
        end
        mse_pkg::KIND_SPEED: begin
          accel_o  <= 32'(upd_m[cur_r]);
          decel_o  <= 32'(dnd_m[cur_r]);
          vel_sp_o <= (phase_r == mse_pkg::MSE_DECEL) ? '0 :
                      (vel_neg ? -$signed(vel_red) : $signed(vel_red));
        end
        default: begin
          accel_o   <= 32'(upd_m[cur_r]);
          cur_cap_o <= cap_m[cur_r];
          vel_sp_o  <= vel_neg ? -$signed(vel_red) : $signed(vel_red);
        end
      endcase
    end
  end
  // home point loads the position counter with the offset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pos_load_o     <= 1'b0;
      pos_load_val_o <= '0;
    end else begin
      pos_load_o     <= (phase_r == mse_pkg::MSE_RAMP) &&
                        (kind_r == mse_pkg::KIND_HOME) && home_point;
      pos_load_val_o <= pos_m[cur_r];
    end
  end
  // capture at expiry of a timed torque hold, readable over the port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      capture_pos_o <= '0;
      prm_rdata     <= '0;
    end else begin
      if (phase_r == mse_pkg::MSE_HOLD && !endless && ms_r >= run_len &&
          !stop_req)
        capture_pos_o <= motor_pos;
      prm_rdata <= prm_re ? capture_pos_o : '0;
    end
  end

  // status outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ferr_off_o   <= 1'b0;
      busy_o       <= 1'b0;
      exec_entry_o <= '0;
    end else begin
      ferr_off_o   <= (phase_r != mse_pkg::MSE_IDLE) &&
                      (kind_r == mse_pkg::KIND_TORQUE) &&
                      (phase_r != mse_pkg::MSE_LOAD);
      busy_o       <= (phase_r != mse_pkg::MSE_IDLE);
      exec_entry_o <= cur_r;
    end
  end

  // ==========================================================
  // checks
  start_leaves_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_IDLE && start_rise && !stop_req
    |=> phase_r == mse_pkg::MSE_LOAD)
    else $error("start edge ignored");
  stop_to_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    stop_req && phase_r != mse_pkg::MSE_IDLE |=> phase_r == mse_pkg::MSE_IDLE)
    else $error("stop not honoured");
  bad_kind_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_LOAD && launch_ok && !kind_ok && !stop_req
    |=> phase_r == mse_pkg::MSE_IDLE)
    else $error("unsupported kind ran");
  skip_alt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_LOAD && !launch_ok && !stop_req
    |=> cur_r == $past(alt_m[cur_r]) && phase_r == mse_pkg::MSE_LOAD)
    else $error("launch skip wrong");
  no_reverse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_RUN || phase_r == mse_pkg::MSE_HOLD
    |=> vel_sp_o == '0 || vel_sp_o[31] == $past(vel_neg))
    else $error("modulation reversed speed");
  ferr_off_trq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_HOLD |=> ferr_off_o)
    else $error("following error active");
  zero_decel_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_RUN && !stop_req && !endless && ms_r >= run_len
    && dnd_m[cur_r] == mse_pkg::ZERO16 |=> phase_r == mse_pkg::MSE_DONE)
    else $error("ramp down not skipped");
  capture_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_HOLD && !endless && ms_r >= run_len && !stop_req
    |=> capture_pos_o == $past(motor_pos) ##1 phase_r == mse_pkg::MSE_LOAD)
    else $error("capture missed");
  sensorless_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    phase_r == mse_pkg::MSE_LOAD && launch_ok && sensorless && !stop_req &&
    ck == mse_pkg::KIND_TORQUE |=> phase_r == mse_pkg::MSE_IDLE)
    else $error("torque run sensorless");
endmodule : mse_top

`default_nettype wire

// ### verification/mse_loop_model.sv
// motor control loop model answering the sequence executor
`timescale 1ns/1ns
`default_nettype none
module mse_loop_model (
  input  wire logic        clk_sys,        // drive clock
  input  wire logic        arst_n,         // async reset, low
  input  wire logic [2:0]  mode_i,         // kind being run
  input  wire logic [15:0] cap_i,          // current cap
  output logic      [31:0] motor_pos,      // present position
  output logic      [15:0] motor_current,  // current, per mille
  output logic             target_reached, // move finished
  output logic             home_point,     // home point found
  output logic             switch_found    // homing switch seen
);
  logic [7:0] cnt_r;  // cycles since the drive became active
  logic       at_cap; // torque move pressing against its load
  // current climbs to the cap a while after a torque move starts
  assign at_cap         = (mode_i == 3'h4) && (cnt_r > 8'h14);
  assign motor_current  = at_cap ? cap_i : 16'h0010;
  assign target_reached = (mode_i == 3'h1) && (cnt_r > 8'h14);
  assign switch_found   = (mode_i == 3'h2) && (cnt_r > 8'h0A);
  assign home_point     = (mode_i == 3'h2) && (cnt_r > 8'h14);
  // shaft turns while a sequence runs and stalls when pressing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r     <= 8'h00;
      motor_pos <= 32'h0000_1000;
    end else begin
      cnt_r <= (mode_i == 3'h0) ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hFF};
      if (mode_i != 3'h0 && !at_cap) motor_pos <= motor_pos + 32'h1;
    end
  end
endmodule : mse_loop_model
`default_nettype wire

// ### verification/mse_top_tb_top.sv
// self-checking testbench of the motion sequence executor
`timescale 1ns/1ns
`default_nettype none
module mse_top_tb_top;
  logic        clk_sys, arst_n, prm_we, prm_re, sensorless, mod_enable;
  logic        target_reached, home_point, switch_found, pos_load_o;
  logic        ferr_off_o, busy_o;
  logic [15:0] ctrl_word, cond_inputs, motor_current, cur_cap_o;
  logic [6:0]  seq_select, prm_entry, exec_entry_o;
  logic [4:0]  prm_sub;
  logic [2:0]  mode_o;
  logic [31:0] mod_value, motor_pos, prm_wdata, prm_rdata, pos_sp_o;
  logic [31:0] accel_o, decel_o, pos_load_val_o, capture_pos_o;
  logic signed [31:0] vel_sp_o;
  logic signed [7:0]  home_method_o;
  int          compares, miscompares;
  mse_top i_dut (.clk_sys, .arst_n, .ctrl_word, .seq_select, .cond_inputs,
    .sensorless, .mod_enable, .mod_value, .motor_pos, .motor_current,
    .target_reached, .home_point, .switch_found, .prm_we, .prm_entry,
    .prm_sub, .prm_wdata, .prm_re, .prm_rdata, .mode_o, .vel_sp_o,
    .pos_sp_o, .accel_o, .decel_o, .cur_cap_o, .home_method_o, .pos_load_o,
    .pos_load_val_o, .ferr_off_o, .capture_pos_o, .busy_o, .exec_entry_o);
  mse_loop_model i_loop (.clk_sys, .arst_n, .mode_i(mode_o),
    .cap_i(cur_cap_o), .motor_pos, .motor_current, .target_reached,
    .home_point, .switch_found);
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, d);
    compares++;
    if (d !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, d);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [6:0] e, input logic [4:0] s,
                    input logic [31:0] d);
    @(posedge clk_sys);
    prm_we    <= 1'b1;
    prm_entry <= e;
    prm_sub   <= s;
    prm_wdata <= d;
    @(posedge clk_sys);
    prm_we    <= 1'b0;
  endtask : wr
  // clears a whole entry, then sets kind, velocity and position
  task automatic ent(input logic [6:0] e, input logic [7:0] k,
                     input logic [31:0] v, p);
    for (int i = 1; i < 26; i++) wr(e, 5'(i), 32'h0);
    wr(e, 5'd1, {24'h0, k});
    wr(e, 5'd15, v);
    wr(e, 5'd13, p);
  endtask : ent
  // pulses a control word bit, then lets the setpoints settle
  task automatic cw(input logic [15:0] w, input logic [6:0] e);
    @(posedge clk_sys);
    seq_select <= e;
    ctrl_word  <= w;
    @(posedge clk_sys);
    ctrl_word  <= 16'h0000;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : cw
  task automatic idle;
    for (int i = 0; i < 40000 && busy_o !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    repeat (4) @(posedge clk_sys);
    #1;
    chk("busy", 32'h0, {31'h0, busy_o});
  endtask : idle
  // ==========================================
  // clock, watchdog and tests
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #(100 * 60000);
    miscompares++;
    wrap_up();
  end
  initial begin
    {arst_n, prm_we, prm_re, sensorless, mod_enable} <= '0;
    {ctrl_word, cond_inputs, seq_select, prm_entry, prm_sub} <= '0;
    {mod_value, prm_wdata} <= '0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    ent(7'd0, 8'h00, 32'h0, 32'h0); // every chain not stopped or refused ends on this kind
    ent(7'd1, 8'h01, 32'h500, 32'h12345);
    wr(7'd1, 5'd16, 32'h200);
    wr(7'd1, 5'd17, 32'h3000);
    wr(7'd1, 5'd18, 32'h4000);
    cw(16'h0010, 7'd1);
    chk("mode", 32'h1, {29'h0, mode_o});
    chk("vel", 32'h500, vel_sp_o);
    chk("pos", 32'h12345, pos_sp_o);
    chk("acc", 32'h3000, accel_o);
    chk("dec", 32'h4000, decel_o);
    idle();
    ent(7'd5, 8'h01, 32'h500, 32'h0);
    wr(7'd5, 5'd2, 32'h5);
    wr(7'd5, 5'd3, 32'h2);
    cw(16'h0010, 7'd5);
    idle();
    ent(7'd6, 8'h03, 32'h0, 32'h0);
    wr(7'd6, 5'd10, 32'h1);
    wr(7'd6, 5'd4, 32'h1);
    cw(16'h0010, 7'd6);
    chk("skip", 32'h1, {25'h0, exec_entry_o});
    idle();
    $display("positioning test done");
    ent(7'd2, 8'h02, 32'h300, 32'h1234);
    wr(7'd2, 5'd22, 32'hFFFF_FFFE);
    wr(7'd2, 5'd16, 32'h80);
    wr(7'd2, 5'd25, 32'h12C);
    cw(16'h0010, 7'd2);
    chk("mode", 32'h2, {29'h0, mode_o});
    chk("method", 32'hFE, {24'h0, home_method_o});
    chk("cap", 32'h12C, {16'h0, cur_cap_o});
    chk("vel", 32'h300, vel_sp_o);
    for (int i = 0; i < 200 && pos_load_o !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("load", 32'h1, {31'h0, pos_load_o});
    chk("load val", 32'h1234, pos_load_val_o);
    chk("vel2", 32'h80, vel_sp_o);
    idle();
    $display("homing test done");
    ent(7'd3, 8'h03, 32'd1000, 32'h0);
    wr(7'd3, 5'd24, 32'hFFFF);
    mod_enable <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      mod_value <= i ? 32'd2000 : 32'd300;
      cw(16'h0010, 7'd3);
      chk("mode", 32'h3, {29'h0, mode_o});
      chk("mod vel", i ? 32'd0 : 32'd700, vel_sp_o);
      repeat (50) @(posedge clk_sys);
      #1;
      chk("endless", 32'h1, {31'h0, busy_o});
      cw(16'h0020, 7'd3);
      idle();
    end
    mod_enable <= 1'b0;
    wr(7'd3, 5'd24, 32'h1);
    cw(16'h0010, 7'd3);
    idle();
    $display("speed test done");
    ent(7'd4, 8'h04, 32'hFFFF_FF00, 32'h0);
    wr(7'd4, 5'd25, 32'h1F4);
    wr(7'd4, 5'd24, 32'h1);
    cw(16'h0010, 7'd4);
    chk("mode", 32'h4, {29'h0, mode_o});
    chk("entry", 32'h4, {25'h0, exec_entry_o});
    chk("ferr off", 32'h1, {31'h0, ferr_off_o});
    chk("vel", 32'hFFFF_FF00, vel_sp_o);
    chk("cap", 32'h1F4, {16'h0, cur_cap_o});
    idle();
    chk("capture", motor_pos, capture_pos_o);
    @(posedge clk_sys);
    prm_re <= 1'b1;
    @(posedge clk_sys);
    prm_re <= 1'b0;
    #1;
    chk("capture read", motor_pos, prm_rdata);
    sensorless <= 1'b1;
    cw(16'h0010, 7'd4);
    chk("refused", 32'h0, {28'h0, busy_o, mode_o});
    $display("torque test done");
    wrap_up();
  end
endmodule : mse_top_tb_top
`default_nettype wire
